// ---- src/tsc_pkg.sv ----
// Package for the capacitive touch scanner: field widths, reset values and states
// Functional notes
// RQ1 - Charge and discharge sources make triangular swing
// RQ2 - Delta voltage sets swing for both oscillators
// RQ3 - Period measured in reference oscillator cycles
// RQ4 - Reference oscillator matches electrode, internal capacitor
// RQ5 - Touch slows electrode, count rises
// RQ6 - Sixteen channels, only selected one scanned
// RQ7 - Channel never advances by itself
// RQ8 - Result counter is sixteen bits
// RQ9 - Scans accumulated, up to 4096 per measurement
// RQ10 - Total scans equal scan number times prescaler
// RQ11 - Result compared against upper and lower thresholds
// RQ12 - Trigger mode bit picks software or hardware
// RQ13 - Software trigger scans exactly once
// RQ14 - Hardware trigger rescans at timer period
// RQ15 - Stop mode enable keeps scanning in low power
// RQ16 - Low power detection raises system wake-up
// RQ17 - Enable and select pick end-of-scan or range interrupt
// RQ18 - Separate charge currents for electrode and reference
// RQ19 - Data register holds channel and DMA enable
// RQ20 - Software enables module last
// RQ21 - Software reconfigures only when not scanning
// RQ22 - Software clears flags before enabling interrupts
// RQ23 - Busy flag spans scan, then end-of-scan flag
// RQ24 - Out-of-range flag when result outside thresholds
// RQ25 - Flags clear on write one
// RQ26 - Interrupt raised after result output
package tsc_pkg;
    localparam int TSC_CNT_W      = 16;
    localparam int TSC_CH_W       = 4;
    localparam int TSC_SCAN_NUMBER_W     = 5;
    localparam int TSC_PS_W       = 3;
    localparam int TSC_CHRG_W     = 3;
    localparam int TSC_DELTA_VOLTAGE_FIELD_W    = 2;
    localparam int TSC_SCANS_W    = 13;
    localparam logic [TSC_CNT_W-1:0]   TSC_CNT_RST   = 16'h0000;
    localparam logic [TSC_SCANS_W-1:0] TSC_SCANS_MAX = 13'h1000;
    localparam logic [TSC_SCANS_W-1:0] TSC_SCANS_RST = 13'h0000;

    typedef enum logic [2:0] {
        TSC_IDLE = 3'b001,
        TSC_SCAN = 3'b010,
        TSC_DONE = 3'b100
    } tsc_state_t;
endpackage : tsc_pkg

// ---- src/tsc_sync.sv ----
// Two-stage synchroniser bank for pin-side inputs
module tsc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_nrst,
    // Data
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s1_nxt;
    logic [W-1:0] s2_nxt;

    always_comb begin
        s1_nxt = i_d;
        s2_nxt = s1_r;
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
        end
    end

    assign o_q = s2_r;
endmodule : tsc_sync

// ---- src/tsc_top.sv ----
// Capacitive touch scanner: scan sequencing, period counting, threshold and flag logic
module tsc_top
    import tsc_pkg::*;
#(
    parameter int CNT_W = TSC_CNT_W,
    parameter int CH_W  = TSC_CH_W
) (
    // Clock and reset
    input  wire logic                   I_CLK_SYS,
    input  wire logic                   I_NRST,
    // Control
    input  wire logic                   I_MODULE_ENABLE,
    input  wire logic                   I_SCAN_TRIGGER_MODE,
    input  wire logic                   I_STOP_MODE_ENABLE,
    input  wire logic                   I_LOW_POWER,
    input  wire logic                   I_INTERRUPT_ENABLE,
    input  wire logic                   I_EVENT_SELECT,
    input  wire logic                   I_SW_TRIGGER,
    input  wire logic                   I_LOW_POWER_TIMER_TRIG,
    input  wire logic [TSC_SCAN_NUMBER_W-1:0]  I_SCAN_NUMBER,
    input  wire logic [TSC_PS_W-1:0]    I_PRESCALER,
    input  wire logic [TSC_CHRG_W-1:0]  I_ELECTRODE_CHARGE_CURRENT,
    input  wire logic [TSC_CHRG_W-1:0]  I_REFERENCE_CHARGE_CURRENT,
    input  wire logic [TSC_DELTA_VOLTAGE_FIELD_W-1:0] I_DELTA_VOLTAGE_FIELD,
    input  wire logic [CNT_W-1:0]       I_THRESHOLD_HIGH,
    input  wire logic [CNT_W-1:0]       I_THRESHOLD_LOW,
    // Data register fields
    input  wire logic [CH_W-1:0]        I_CHANNEL_SELECT,
    input  wire logic                   I_DMA_ENABLE,
    // Flag clears, write one to clear
    input  wire logic                   I_CLR_END_OF_SCAN,
    input  wire logic                   I_CLR_OUT_OF_RANGE,
    // Analog comparator outputs, asynchronous
    input  wire logic                   I_ELECTRODE_CMP,
    input  wire logic                   I_REFERENCE_CMP,
    // Analog front-end controls
    output logic [(1<<CH_W)-1:0]        O_ELECTRODE_SELECT,
    output logic                        O_ELECTRODE_CHARGE,
    output logic                        O_ELECTRODE_DISCHARGE,
    output logic                        O_REFERENCE_CHARGE,
    output logic                        O_REFERENCE_DISCHARGE,
    output logic [TSC_CHRG_W-1:0]       O_ELECTRODE_CURRENT,
    output logic [TSC_CHRG_W-1:0]       O_REFERENCE_CURRENT,
    output logic [TSC_DELTA_VOLTAGE_FIELD_W-1:0]      O_DELTA_VOLTAGE,
    // Status and results
    output logic [CNT_W-1:0]            O_RESULT,
    output logic                        O_SCAN_IN_PROGRESS,
    output logic                        O_END_OF_SCAN_FLAG,
    output logic                        O_OUT_OF_RANGE_FLAG,
    output logic                        O_IRQ,
    output logic                        O_DMA_REQ,
    output logic                        O_WAKEUP
);

    function automatic logic [TSC_SCANS_W-1:0] total_scans(input logic [TSC_SCAN_NUMBER_W-1:0] n,
                                                           input logic [TSC_PS_W-1:0] ps);
        logic [TSC_SCANS_W-1:0] t;
        t = TSC_SCANS_W'({8'h00, n} + 13'h0001) << ps;
        if (t > TSC_SCANS_MAX) begin
            t = TSC_SCANS_MAX;
        end
        return t;
    endfunction : total_scans

    // Period boundary: comparator high now, low one cycle before
    function automatic logic rise(input logic now_v, input logic was_v);
        return now_v && !was_v;
    endfunction : rise

    // Pad enable for one channel; every other pad stays disconnected
    function automatic logic [(1<<CH_W)-1:0] chan_onehot(input logic [CH_W-1:0] ch);
        logic [(1<<CH_W)-1:0] v;
        v     = '0;
        v[ch] = 1'b1;
        return v;
    endfunction : chan_onehot

    // Comparator outputs cross from the analog side
    logic [1:0] cmp_s;
    tsc_sync #(.W(2)) u_sync (
        .i_clk  (I_CLK_SYS),
        .i_nrst (I_NRST),
        .i_d    ({I_ELECTRODE_CMP, I_REFERENCE_CMP}),
        .o_q    (cmp_s)
    );
    logic el_cmp;
    logic rf_cmp;
    assign el_cmp = cmp_s[1];
    assign rf_cmp = cmp_s[0];

    tsc_state_t             state_r,    state_nxt;
    logic [CNT_W-1:0]       acc_r,      acc_nxt;
    logic [CNT_W-1:0]       result_r,   result_nxt;
    logic [TSC_SCANS_W-1:0] scans_r,    scans_nxt;
    logic [CH_W-1:0]        chan_r,     chan_nxt;
    logic                   el_up_r,    el_up_nxt;
    logic                   rf_up_r,    rf_up_nxt;
    logic                   el_prev_r,  el_prev_nxt;
    logic                   rf_prev_r,  rf_prev_nxt;
    logic                   eos_r,      eos_nxt;
    logic                   oor_r,      oor_nxt;
    logic                   dma_r,      dma_nxt;
    logic                   wake_r,     wake_nxt;
    logic                   el_period;
    logic                   rf_period;
    logic                   trig;
    logic                   lp_scan;
    logic                   done_evt;
    logic                   range_bad;
    logic                   scan_end;
    // Front-end drive registers
    logic [(1<<CH_W)-1:0]   sel_r,      sel_nxt;
    logic [3:0]             drive_r,    drive_nxt;
    logic [TSC_CHRG_W-1:0]  ecur_r,     ecur_nxt;
    logic [TSC_CHRG_W-1:0]  rcur_r,     rcur_nxt;
    logic [TSC_DELTA_VOLTAGE_FIELD_W-1:0] delta_voltage_field_r,    delta_voltage_field_nxt;

    // Electrode period ends on each rising comparator edge; same for reference
    assign el_period = rise(el_cmp, el_prev_r);
    assign rf_period = rise(rf_cmp, rf_prev_r);
    // Low power scanning runs only with stop mode enabled, under either trigger mode
    assign lp_scan   = I_LOW_POWER && I_STOP_MODE_ENABLE; // RQ15
    assign trig      = I_MODULE_ENABLE && (!I_LOW_POWER || lp_scan) &&
                       (I_SCAN_TRIGGER_MODE ? I_LOW_POWER_TIMER_TRIG : I_SW_TRIGGER); // RQ12 RQ14
    assign done_evt  = (state_r == TSC_DONE);
    // Scan finishes on this cycle's last electrode period
    assign scan_end  = (state_r == TSC_SCAN) && (state_nxt == TSC_DONE);
    assign range_bad = (result_nxt > I_THRESHOLD_HIGH) || (result_nxt < I_THRESHOLD_LOW); // RQ11

    // Comparator trips swap the current source direction: triangle wave
    always_comb begin
        el_up_nxt = 1'b0;
        rf_up_nxt = 1'b0;
        if (state_r == TSC_SCAN) begin
            el_up_nxt = el_cmp ? 1'b0 : (!el_up_r && !el_cmp ? 1'b1 : el_up_r); // RQ1
            rf_up_nxt = rf_cmp ? 1'b0 : (!rf_up_r && !rf_cmp ? 1'b1 : rf_up_r); // RQ4
        end
    end

    always_comb begin
        el_prev_nxt = el_cmp;
        rf_prev_nxt = rf_cmp;
    end

    // Scan sequencer: one measurement per accepted trigger
    always_comb begin
        state_nxt  = state_r;
        acc_nxt    = acc_r;
        result_nxt = result_r;
        scans_nxt  = scans_r;
        chan_nxt   = chan_r;
        case (state_r)
            TSC_IDLE: begin
                if (trig) begin
                    state_nxt = TSC_SCAN;
                    acc_nxt   = TSC_CNT_RST;
                    scans_nxt = total_scans(I_SCAN_NUMBER, I_PRESCALER); // RQ9 RQ10
                    chan_nxt  = I_CHANNEL_SELECT; // RQ6 RQ7
                end
            end
            TSC_SCAN: begin
                // Reference edges counted, not system clock cycles
                if (rf_period && acc_r != {CNT_W{1'b1}}) begin
                    acc_nxt = acc_r + 1'b1; // RQ3 RQ5 RQ8
                end
                if (el_period) begin
                    scans_nxt = scans_r - 1'b1;
                    if (scans_r == 13'h0001) begin
                        state_nxt  = TSC_DONE;
                        result_nxt = acc_nxt; // RQ23
                    end
                end
                if (!I_MODULE_ENABLE) begin
                    state_nxt = TSC_IDLE;
                end
            end
            TSC_DONE: begin
                // Single pass back to idle: one scan per software trigger
                state_nxt = TSC_IDLE; // RQ13
            end
            default: begin
                state_nxt = TSC_IDLE;
            end
        endcase
    end

    // Set wins over a write-one clear in the same cycle
    always_comb begin
        eos_nxt  = (eos_r && !I_CLR_END_OF_SCAN) || done_evt; // RQ23 RQ25
        oor_nxt  = (oor_r && !I_CLR_OUT_OF_RANGE) || (scan_end && range_bad); // RQ24 RQ25
        dma_nxt  = done_evt && I_DMA_ENABLE; // RQ19
        wake_nxt = lp_scan && scan_end && range_bad; // RQ16
    end

    // Sequencer registers
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            state_r  <= TSC_IDLE;
            acc_r    <= TSC_CNT_RST;
            result_r <= TSC_CNT_RST;
            scans_r  <= TSC_SCANS_RST;
            chan_r   <= '0;
        end else begin
            state_r  <= state_nxt;
            acc_r    <= acc_nxt;
            result_r <= result_nxt;
            scans_r  <= scans_nxt;
            chan_r   <= chan_nxt;
        end
    end

    // Current source direction
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            el_up_r <= 1'b0;
            rf_up_r <= 1'b0;
        end else begin
            el_up_r <= el_up_nxt;
            rf_up_r <= rf_up_nxt;
        end
    end

    // Edge history resets to the comparators' idle low, so no false period follows reset
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            el_prev_r <= 1'b0;
            rf_prev_r <= 1'b0;
        end else begin
            el_prev_r <= el_prev_nxt;
            rf_prev_r <= rf_prev_nxt;
        end
    end

    // Sticky flags and one-cycle pulses
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            eos_r  <= 1'b0;
            oor_r  <= 1'b0;
            dma_r  <= 1'b0;
            wake_r <= 1'b0;
        end else begin
            eos_r  <= eos_nxt;
            oor_r  <= oor_nxt;
            dma_r  <= dma_nxt;
            wake_r <= wake_nxt;
        end
    end

    // Only the latched channel's pad is connected while scanning
    // Fed from next-state values, so pad controls move on the same edge as busy
    always_comb begin
        sel_nxt   = '0;
        drive_nxt = 4'h0;
        if (state_nxt == TSC_SCAN) begin
            sel_nxt   = chan_onehot(chan_nxt); // RQ6
            drive_nxt = {el_up_nxt, !el_up_nxt, rf_up_nxt, !rf_up_nxt}; // RQ1 RQ4
        end
        // Trim settings registered too, so the analog side never sees a glitch
        ecur_nxt  = I_ELECTRODE_CHARGE_CURRENT; // RQ18
        rcur_nxt  = I_REFERENCE_CHARGE_CURRENT; // RQ18
        delta_voltage_field_nxt = I_DELTA_VOLTAGE_FIELD; // RQ2
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            sel_r   <= '0;
            drive_r <= 4'h0;
            ecur_r  <= '0;
            rcur_r  <= '0;
            delta_voltage_field_r <= '0;
        end else begin
            sel_r   <= sel_nxt;
            drive_r <= drive_nxt;
            ecur_r  <= ecur_nxt;
            rcur_r  <= rcur_nxt;
            delta_voltage_field_r <= delta_voltage_field_nxt;
        end
    end

    assign O_ELECTRODE_SELECT    = sel_r; // RQ6
    assign O_ELECTRODE_CHARGE    = drive_r[3]; // RQ1
    assign O_ELECTRODE_DISCHARGE = drive_r[2]; // RQ1
    assign O_REFERENCE_CHARGE    = drive_r[1]; // RQ4
    assign O_REFERENCE_DISCHARGE = drive_r[0]; // RQ4
    assign O_ELECTRODE_CURRENT   = ecur_r; // RQ18
    assign O_REFERENCE_CURRENT   = rcur_r; // RQ18
    assign O_DELTA_VOLTAGE       = delta_voltage_field_r; // RQ2
    assign O_RESULT              = result_r;
    assign O_SCAN_IN_PROGRESS    = (state_r == TSC_SCAN); // RQ23
    assign O_END_OF_SCAN_FLAG    = eos_r;
    assign O_OUT_OF_RANGE_FLAG   = oor_r;
    // Level interrupt follows the chosen sticky flag
    assign O_IRQ = I_INTERRUPT_ENABLE && (I_EVENT_SELECT ? eos_r : oor_r); // RQ17 RQ26
    assign O_DMA_REQ = dma_r;
    assign O_WAKEUP  = wake_r;
endmodule : tsc_top

// ---- dv/tsc_props.sv ----
// Checker for scan sequencing, flags and interrupt mapping
module tsc_props
    import tsc_pkg::*;
#(
    parameter int CNT_W = TSC_CNT_W,
    parameter int CH_W  = TSC_CH_W
) (
    // Clock, reset and control
    input wire logic                  I_CLK_SYS,
    input wire logic                  I_NRST,
    input wire logic                  I_MODULE_ENABLE,
    input wire logic                  I_SCAN_TRIGGER_MODE,
    input wire logic                  I_STOP_MODE_ENABLE,
    input wire logic                  I_LOW_POWER,
    input wire logic                  I_INTERRUPT_ENABLE,
    input wire logic                  I_EVENT_SELECT,
    input wire logic                  I_SW_TRIGGER,
    input wire logic [CNT_W-1:0]      I_THRESHOLD_HIGH,
    input wire logic [CNT_W-1:0]      I_THRESHOLD_LOW,
    input wire logic                  I_DMA_ENABLE,
    input wire logic                  I_CLR_END_OF_SCAN,
    input wire logic                  I_CLR_OUT_OF_RANGE,
    // Watched outputs
    input wire logic [(1<<CH_W)-1:0]  O_ELECTRODE_SELECT,
    input wire logic [CNT_W-1:0]      O_RESULT,
    input wire logic                  O_SCAN_IN_PROGRESS,
    input wire logic                  O_END_OF_SCAN_FLAG,
    input wire logic                  O_OUT_OF_RANGE_FLAG,
    input wire logic                  O_IRQ,
    input wire logic                  O_DMA_REQ,
    input wire logic                  O_WAKEUP
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_NRST);
    // The done cycle after busy falls refuses triggers, so a start needs two idle cycles
    sequence sw_start_s;
        I_SW_TRIGGER && !I_SCAN_TRIGGER_MODE && I_MODULE_ENABLE && !I_LOW_POWER && !O_SCAN_IN_PROGRESS
            && !$past(O_SCAN_IN_PROGRESS);
    endsequence
    sequence scan_end_s;
        $fell(O_SCAN_IN_PROGRESS) && $past(I_MODULE_ENABLE);
    endsequence
    sequence oor_end_s;
        $fell(O_SCAN_IN_PROGRESS) && (O_RESULT > I_THRESHOLD_HIGH || O_RESULT < I_THRESHOLD_LOW);
    endsequence
    start_busy_a: assert property (sw_start_s |=> O_SCAN_IN_PROGRESS) else $error("scan not started");
    lp_refuse_a: assert property (I_LOW_POWER && !I_STOP_MODE_ENABLE && !O_SCAN_IN_PROGRESS
        |=> !O_SCAN_IN_PROGRESS) else $error("low power scan");
    sel_onehot_a: assert property (O_SCAN_IN_PROGRESS ? $onehot(O_ELECTRODE_SELECT)
        : O_ELECTRODE_SELECT == '0) else $error("bad select");
    sel_hold_a: assert property (O_SCAN_IN_PROGRESS && $past(O_SCAN_IN_PROGRESS)
        |-> $stable(O_ELECTRODE_SELECT)) else $error("select moved");
    eos_set_a: assert property (scan_end_s |=> O_END_OF_SCAN_FLAG) else $error("no end flag");
    oor_set_a: assert property (oor_end_s |-> O_OUT_OF_RANGE_FLAG) else $error("no range flag");
    irq_map_a: assert property (O_IRQ == (I_INTERRUPT_ENABLE &&
        (I_EVENT_SELECT ? O_END_OF_SCAN_FLAG : O_OUT_OF_RANGE_FLAG))) else $error("irq mismatch");
    eos_clr_a: assert property (I_CLR_END_OF_SCAN && !$fell(O_SCAN_IN_PROGRESS)
        |=> !O_END_OF_SCAN_FLAG) else $error("end flag not cleared");
    oor_keep_a: assert property (O_OUT_OF_RANGE_FLAG && !I_CLR_OUT_OF_RANGE
        |=> O_OUT_OF_RANGE_FLAG) else $error("range flag lost");
    dma_pulse_a: assert property ($rose(O_END_OF_SCAN_FLAG) |-> O_DMA_REQ == I_DMA_ENABLE ##1 !O_DMA_REQ)
        else $error("dma pulse wrong");
    wake_lp_a: assert property (O_WAKEUP |-> I_LOW_POWER && !O_SCAN_IN_PROGRESS) else $error("stray wake");
endmodule : tsc_props

bind tsc_top tsc_props #(.CNT_W(CNT_W), .CH_W(CH_W)) tsc_props_inst (.*);

// ---- dv/tsc_electrode_model.sv ----
// Electrode and reference comparator model, oscillating only while an electrode is selected
module tsc_electrode_model (
    // Clock and stimulus
    input  wire logic        i_clk,
    input  wire logic [15:0] i_sel,
    input  wire logic        i_touch,
    // Comparator levels
    output logic             o_ecmp = 1'b0,
    output logic             o_rcmp = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    int ecnt = 0;
    int rcnt = 0;
    always @(posedge i_clk) begin
        if (i_sel == 16'h0000) begin
            {ecnt, rcnt, o_ecmp, o_rcmp} <= '0;
        end else begin
            // Touch doubles the electrode half period; reference runs at period 4
            ecnt <= (ecnt == (i_touch ? 39 : 19)) ? 0 : ecnt + 1;
            rcnt <= (rcnt == 1) ? 0 : rcnt + 1;
            o_ecmp <= (ecnt == (i_touch ? 39 : 19)) ? !o_ecmp : o_ecmp;
            o_rcmp <= (rcnt == 1) ? !o_rcmp : o_rcmp;
        end
    end
endmodule : tsc_electrode_model

// ---- dv/tsc_top_test.sv ----
// Self-checking bench for the touch scanner
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; $display("Error %s exp %h got %h", n, e, g); end end
module tsc_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {int nom; logic oor; logic lp; logic dma; logic irq;} tsc_note_t;
    logic I_CLK_SYS = 0, I_NRST, I_MODULE_ENABLE, I_SCAN_TRIGGER_MODE, I_STOP_MODE_ENABLE, I_LOW_POWER;
    logic I_INTERRUPT_ENABLE, I_EVENT_SELECT, I_SW_TRIGGER, I_LOW_POWER_TIMER_TRIG, I_DMA_ENABLE;
    logic I_CLR_END_OF_SCAN, I_CLR_OUT_OF_RANGE, touch, was_busy = 0;
    logic [4:0] I_SCAN_NUMBER;
    logic [2:0] I_PRESCALER, I_ELECTRODE_CHARGE_CURRENT, I_REFERENCE_CHARGE_CURRENT;
    logic [1:0] I_DELTA_VOLTAGE_FIELD;
    logic [15:0] I_THRESHOLD_HIGH, I_THRESHOLD_LOW;
    logic [3:0] I_CHANNEL_SELECT;
    wire logic I_ELECTRODE_CMP, I_REFERENCE_CMP, O_ELECTRODE_CHARGE, O_ELECTRODE_DISCHARGE, O_REFERENCE_CHARGE;
    wire logic O_REFERENCE_DISCHARGE, O_SCAN_IN_PROGRESS, O_END_OF_SCAN_FLAG, O_OUT_OF_RANGE_FLAG;
    wire logic O_IRQ, O_DMA_REQ, O_WAKEUP;
    wire logic [15:0] O_ELECTRODE_SELECT, O_RESULT;
    wire logic [2:0] O_ELECTRODE_CURRENT, O_REFERENCE_CURRENT;
    wire logic [1:0] O_DELTA_VOLTAGE;
    int err_count = 0;
    int num_checks = 0;
    tsc_note_t q[$];
    tsc_note_t nt;

    tsc_top tsc_top_inst (.*);
    tsc_electrode_model tsc_electrode_model_inst (.i_clk(I_CLK_SYS), .i_sel(O_ELECTRODE_SELECT),
        .i_touch(touch), .o_ecmp(I_ELECTRODE_CMP), .o_rcmp(I_REFERENCE_CMP));

    always #5 I_CLK_SYS = ~I_CLK_SYS;

    task automatic wrap_up();
        if (err_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    // Configure only while idle, clear flags, trigger, then hold the trigger one more cycle
    task automatic scan(input logic tch, md, hw, l, s, input int thr);
        int sc;
        int nom;
        int k;
        logic acc;
        @(posedge I_CLK_SYS);
        #1;
        {I_SCAN_NUMBER, I_PRESCALER, I_CHANNEL_SELECT} = {5'($urandom % 4), 3'($urandom % 2), 4'($urandom)};
        {I_EVENT_SELECT, I_INTERRUPT_ENABLE, I_DMA_ENABLE, I_DELTA_VOLTAGE_FIELD} = 5'($urandom);
        {I_ELECTRODE_CHARGE_CURRENT, I_REFERENCE_CHARGE_CURRENT} = 6'($urandom);
        {touch, I_SCAN_TRIGGER_MODE, I_LOW_POWER, I_STOP_MODE_ENABLE} = {tch, md, l, s};
        acc = (md == hw) && (!l || s);
        sc = (I_SCAN_NUMBER + 1) << I_PRESCALER;
        nom = (tch ? 10 : 5) * (2 * sc - 1);
        I_THRESHOLD_HIGH = 16'((thr == 1) ? nom / 4 : nom * 4);
        I_THRESHOLD_LOW = 16'((thr == 2) ? nom * 4 : nom / 4);
        {I_CLR_END_OF_SCAN, I_CLR_OUT_OF_RANGE} = 2'b11;
        @(posedge I_CLK_SYS);
        #1;
        {I_CLR_END_OF_SCAN, I_CLR_OUT_OF_RANGE} = 2'b00;
        `CHK("flags", 2'b00, {O_END_OF_SCAN_FLAG, O_OUT_OF_RANGE_FLAG})
        `CHK("copies", {I_ELECTRODE_CHARGE_CURRENT, I_REFERENCE_CHARGE_CURRENT, I_DELTA_VOLTAGE_FIELD},
            {O_ELECTRODE_CURRENT, O_REFERENCE_CURRENT, O_DELTA_VOLTAGE})
        {I_LOW_POWER_TIMER_TRIG, I_SW_TRIGGER} = hw ? 2'b10 : 2'b01;
        if (acc) q.push_back('{nom, thr != 0, l && (thr != 0), I_DMA_ENABLE,
            I_INTERRUPT_ENABLE & (I_EVENT_SELECT | (thr != 0))});
        @(posedge I_CLK_SYS);
        #1;
        `CHK("busy", acc, O_SCAN_IN_PROGRESS)
        if (acc) `CHK("select", 16'h0001 << I_CHANNEL_SELECT, O_ELECTRODE_SELECT)
        @(posedge I_CLK_SYS);
        #1;
        {I_LOW_POWER_TIMER_TRIG, I_SW_TRIGGER} = 2'b00;
        if (acc) `CHK("hold", 16'h0001 << I_CHANNEL_SELECT, O_ELECTRODE_SELECT)
        `CHK("drive", {acc, acc},
            {O_ELECTRODE_CHARGE, O_REFERENCE_CHARGE} ^ {O_ELECTRODE_DISCHARGE, O_REFERENCE_DISCHARGE})
        // Nothing is reconfigured until the scan has finished
        for (k = 0; k < 2000 && O_SCAN_IN_PROGRESS === 1'b1; k++) @(posedge I_CLK_SYS);
        repeat (4) @(posedge I_CLK_SYS);
        #1;
        `CHK("once", 1'b0, O_SCAN_IN_PROGRESS)
        `CHK("idle drive", 4'h0,
            {O_ELECTRODE_CHARGE, O_ELECTRODE_DISCHARGE, O_REFERENCE_CHARGE, O_REFERENCE_DISCHARGE})
    endtask : scan

    // Result and range at the fall of busy, end flag one cycle later
    initial forever begin
        @(negedge I_CLK_SYS);
        if (was_busy && O_SCAN_IN_PROGRESS === 1'b0) begin
            nt = q.pop_front();
            `CHK("result", 1'b1, O_RESULT + 6 >= nt.nom && O_RESULT <= nt.nom + 6)
            `CHK("range", nt.oor, O_OUT_OF_RANGE_FLAG)
            `CHK("wake", nt.lp, O_WAKEUP)
            @(negedge I_CLK_SYS);
            `CHK("eos", 1'b1, O_END_OF_SCAN_FLAG)
            `CHK("dma", nt.dma, O_DMA_REQ)
            `CHK("irq", nt.irq, O_IRQ)
        end
        was_busy = O_SCAN_IN_PROGRESS;
    end

    initial begin
        #300000;
        `CHK("watchdog", 1'b0, 1'b1)
        wrap_up();
    end

    initial begin
        int k;
        {I_NRST, I_MODULE_ENABLE, I_SCAN_TRIGGER_MODE, I_STOP_MODE_ENABLE, I_LOW_POWER, touch} = '0;
        {I_INTERRUPT_ENABLE, I_EVENT_SELECT, I_SW_TRIGGER, I_LOW_POWER_TIMER_TRIG, I_DMA_ENABLE} = '0;
        {I_CLR_END_OF_SCAN, I_CLR_OUT_OF_RANGE, I_SCAN_NUMBER, I_PRESCALER, I_CHANNEL_SELECT} = '0;
        {I_ELECTRODE_CHARGE_CURRENT, I_REFERENCE_CHARGE_CURRENT, I_DELTA_VOLTAGE_FIELD} = '0;
        {I_THRESHOLD_HIGH, I_THRESHOLD_LOW} = '0;
        k = $urandom(32'h3027);
        repeat (2) @(posedge I_CLK_SYS);
        #1;
        I_NRST = 1'b1;
        I_MODULE_ENABLE = 1'b1;
        for (k = 0; k < 6; k++) scan(1'($urandom), 0, 0, 0, 0, k % 3);
        scan(0, 1, 1, 0, 0, 0);
        scan(1, 1, 1, 0, 0, 1);
        scan(1, 1, 0, 0, 0, 1);
        scan(1, 1, 1, 1, 0, 1);
        scan(1, 1, 1, 1, 1, 2);
        wrap_up();
    end
endmodule : tsc_top_test
